// ===== common/cspe_pkg.sv
// How it works
// - push stores the return address and zero to twelve saved registers
// - extra stack space is added or released in sixteen byte steps
// - register list codes zero to three are reserved and trap as illegal
// - capability mode push stores full capabilities, checked against stack capability
// - legacy push stores integer registers, checked against default data capability
// - failed push check reports data fault with tag, seal, permission or length cause
// - failed pop check reports data fault with tag, seal, read permission or length
// - pop reloads return address and saved registers, then releases the frame
// - return variants jump through the reloaded return address after the frame is gone
// - return variant loads are checked like ordinary loads of the mode
// - return target checked against return capability, or program counter capability
// - load faults report data type, return faults report instruction access type
// - return-zero variant clears argument register zero before returning
// - return variants and table jumps are illegal while in debug mode
// - paired moves use three bit saved register specifiers
// - specifiers 0 and 1 are x8 and x9, 2 to 7 are x18 to x23
// - paired moves copy argument pair to saved pair or back
// - both writes of a paired move land in one cycle
// - table entries are plain address-width words in either mode
// - table base register is a capability-width alias port
// - table reads are checked against the table capability, never the code capability
// - valid entry range is recomputed after each table capability write
package cspe_pkg;
	localparam int XLEN = 32;
	localparam int CAPW = 2 * XLEN;
	localparam int SLOT_INT = XLEN / 8;
	localparam int SLOT_CAP = CAPW / 8;
	localparam int ADJ_UNIT = 16;
	localparam logic [3:0] RLIST_MIN = 4'h4;
	localparam logic [3:0] RLIST_ALL = 4'hf;
	localparam logic [3:0] ALL_REGS = 4'hd;
	localparam logic [4:0] REG_RA = 5'h01;
	localparam logic [4:0] REG_A0 = 5'h0a;
	localparam logic [4:0] REG_A1 = 5'h0b;
	localparam logic [4:0] REG_S0 = 5'h08;
	localparam logic [4:0] REG_S2_OFS = 5'h10;
	localparam logic [1:0] OPC_C2 = 2'h2;
	localparam logic [2:0] F3_ZCM = 3'h5;
	localparam logic [4:0] SEL_PUSH = 5'h18;
	localparam logic [4:0] SEL_POP = 5'h1a;
	localparam logic [4:0] SEL_POPRETZ = 5'h1c;
	localparam logic [4:0] SEL_POPRET = 5'h1e;
	localparam logic [2:0] SEL_MV = 3'h3;
	localparam logic [2:0] SEL_JT = 3'h0;
	localparam logic [1:0] MV_A2S = 2'h1;
	localparam logic [1:0] MV_S2A = 2'h3;
	localparam logic [7:0] JALT_MIN = 8'h20;
	localparam logic [1:0] FT_DATA = 2'h1;
	localparam logic [1:0] FT_IFETCH = 2'h2;
	localparam logic [3:0] CAUSE_NONE = 4'h0;
	localparam logic [3:0] CAUSE_TAG = 4'h1;
	localparam logic [3:0] CAUSE_SEAL = 4'h2;
	localparam logic [3:0] CAUSE_PERM = 4'h3;
	localparam logic [3:0] CAUSE_LEN = 4'h4;
	typedef struct packed {
		logic tag;
		logic sealed;
		logic perm_r;
		logic perm_w;
		logic perm_x;
		logic [XLEN-1:0] base;
		logic [XLEN:0] top;
		logic [XLEN-1:0] addr;
	} cspe_cap_t;
	typedef struct packed {
		logic valid;
		logic [4:0] addr;
		logic [CAPW-1:0] data;
		logic valid2;
		logic [4:0] addr2;
		logic [CAPW-1:0] data2;
	} cspe_regwr_t;
	typedef struct packed {
		logic valid;
		logic we;
		logic cap;
		logic [XLEN-1:0] addr;
		logic [CAPW-1:0] wdata;
	} cspe_mem_t;
	typedef struct packed {
		logic valid;
		logic [1:0] ftype;
		logic [3:0] cause;
	} cspe_fault_t;
	typedef struct packed {
		logic valid;
		logic link;
		logic [XLEN-1:0] target;
	} cspe_jump_t;
	typedef enum logic [2:0] {OP_PUSH, OP_POP, OP_POPRET, OP_POPRETZ, OP_MVA2S, OP_MVS2A, OP_JT} cspe_op_t;
	typedef enum logic [2:0] {S_IDLE, S_PRD, S_LD, S_WAIT, S_SP, S_RET, S_MV, S_JT} cspe_st_t;
endpackage : cspe_pkg

// ===== rtl/cspe_exec.sv
`timescale 1ns/1ps
module cspe_exec (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               instr_valid,
	input  wire logic [15:0]        instr,
	input  wire logic               cap_mode,
	input  wire logic               debug_mode,
	input  wire logic [cspe_pkg::XLEN-1:0] sp_addr,
	input  wire cspe_pkg::cspe_cap_t sp_cap,
	input  wire cspe_pkg::cspe_cap_t ddc_cap,
	input  wire cspe_pkg::cspe_cap_t pcc_cap,
	input  wire cspe_pkg::cspe_cap_t ret_cap,
	input  wire cspe_pkg::cspe_cap_t jvt_cap,
	input  wire logic               jvt_write,
	input  wire logic [cspe_pkg::CAPW-1:0] reg_rdata,
	input  wire logic               mem_ack,
	input  wire logic [cspe_pkg::CAPW-1:0] mem_rdata,
	output logic                    busy,
	output logic [4:0]              reg_raddr,
	output cspe_pkg::cspe_regwr_t   reg_wr,
	output cspe_pkg::cspe_mem_t     mem,
	output logic                    sp_we,
	output logic [cspe_pkg::XLEN-1:0] sp_wdata,
	output cspe_pkg::cspe_jump_t    jump,
	output cspe_pkg::cspe_fault_t   fault,
	output logic                    illegal,
	output logic                    done
);
	import cspe_pkg::*;

	typedef struct packed {
		cspe_st_t st;
		cspe_op_t op;
		logic cm;
		logic [3:0] nregs;
		logic [3:0] k;
		logic [XLEN-1:0] adj;
		logic [XLEN-1:0] sp;
		logic [2:0] s2;
		logic [7:0] index;
		logic [8:0] jvt_cnt;
		logic [3:0] jvt_cause;
		logic busy;
		logic [4:0] raddr;
		cspe_regwr_t wr;
		cspe_mem_t mem;
		logic sp_we;
		logic [XLEN-1:0] sp_wdata;
		cspe_jump_t jump;
		cspe_fault_t fault;
		logic illegal;
		logic done;
	} cspe_state_t;

	cspe_state_t r;
	cspe_state_t n;

	// saved-register specifier to register number
	function automatic logic [4:0] sreg_x(input logic [3:0] s);
		if (s < 4'h2)
			return REG_S0 + {1'b0, s};
		else
			return REG_S2_OFS + {1'b0, s};
	endfunction : sreg_x

	// frame slot k: return address first, then s0 upward
	function automatic logic [4:0] frame_x(input logic [3:0] k);
		if (k == 4'h0)
			return REG_RA;
		else
			return sreg_x(k - 4'h1);
	endfunction : frame_x

	// authority check, priority tag, seal, permission, length
	function automatic logic [3:0] chk(input cspe_cap_t c, input logic p, input logic [XLEN-1:0] a,
		input logic [XLEN:0] nb);
		if (!c.tag)
			return CAUSE_TAG;
		else if (c.sealed)
			return CAUSE_SEAL;
		else if (!p)
			return CAUSE_PERM;
		else if (a < c.base || {1'b0, a} + nb > c.top)
			return CAUSE_LEN;
		else
			return CAUSE_NONE;
	endfunction : chk

	logic [XLEN-1:0] slot;
	logic [XLEN-1:0] nbytes;
	logic [XLEN-1:0] addr_ofs;
	logic [XLEN-1:0] acc_addr;
	logic [3:0] rl;
	logic [3:0] rl_n;
	cspe_cap_t auth;
	logic [3:0] cause;
	logic [XLEN:0] jvt_span;

	// decode helpers shared by the sequencer
	always_comb
	begin
		rl = instr[7:4];
		rl_n = (rl == RLIST_ALL) ? ALL_REGS : rl - 4'h3;
		slot = cap_mode ? XLEN'(SLOT_CAP) : XLEN'(SLOT_INT);
		nbytes = XLEN'(rl_n) * slot;
		addr_ofs = XLEN'({1'b0, r.k} + 5'h01) * (r.cm ? XLEN'(SLOT_CAP) : XLEN'(SLOT_INT));
		// push goes below the old sp, pop reads the frame above the current sp
		acc_addr = (r.op == OP_PUSH) ? r.sp - addr_ofs : r.sp + r.adj - addr_ofs;
		auth = r.cm ? sp_cap : ddc_cap;
		jvt_span = jvt_cap.top - {1'b0, jvt_cap.addr};
	end

	// the whole sequencer: one next-state copy per cycle
	always_comb
	begin
		n = r;
		n.wr.valid = 1'b0;
		n.wr.valid2 = 1'b0;
		n.sp_we = 1'b0;
		n.jump.valid = 1'b0;
		n.fault.valid = 1'b0;
		n.illegal = 1'b0;
		n.done = 1'b0;
		cause = CAUSE_NONE;
		// range recomputed on each table-base write, so reads only compare the index
		if (jvt_write)
		begin
			n.jvt_cause = chk(jvt_cap, jvt_cap.perm_x, jvt_cap.base, {(XLEN+1){1'b0}});
			if (jvt_cap.addr < jvt_cap.base || jvt_cap.addr > jvt_cap.top[XLEN-1:0] && !jvt_cap.top[XLEN])
				n.jvt_cnt = 9'h000;
			else if (jvt_span[XLEN:10] != '0)
				n.jvt_cnt = 9'h100;
			else
				n.jvt_cnt = 9'(jvt_span[9:0] >> $clog2(SLOT_INT));
		end
		unique case (r.st)
			S_IDLE:
			begin
				n.busy = 1'b0;
				if (instr_valid)
				begin
					n.busy = 1'b1;
					n.cm = cap_mode;
					n.sp = sp_addr;
					n.k = 4'h0;
					n.nregs = rl_n;
					// frame rounded up to 16 bytes plus the extra multiples
					n.adj = ((nbytes + XLEN'(ADJ_UNIT - 1)) & ~XLEN'(ADJ_UNIT - 1))
						+ XLEN'(instr[3:2]) * XLEN'(ADJ_UNIT);
					n.index = instr[9:2];
					n.s2 = instr[4:2];
					n.raddr = REG_RA;
					n.st = S_IDLE;
					if (instr[1:0] != OPC_C2 || instr[15:13] != F3_ZCM)
						n.illegal = 1'b1;
					else if (instr[12:8] == SEL_PUSH || instr[12:8] == SEL_POP
						|| instr[12:8] == SEL_POPRET || instr[12:8] == SEL_POPRETZ)
					begin
						unique case (instr[12:8])
							SEL_PUSH: n.op = OP_PUSH;
							SEL_POP: n.op = OP_POP;
							SEL_POPRET: n.op = OP_POPRET;
							default: n.op = OP_POPRETZ;
						endcase
						if (rl < RLIST_MIN)
							n.illegal = 1'b1;
						else if (debug_mode && instr[12:8] != SEL_PUSH && instr[12:8] != SEL_POP)
							n.illegal = 1'b1;
						else
							n.st = (instr[12:8] == SEL_PUSH) ? S_PRD : S_LD;
					end
					else if (instr[12:10] == SEL_MV && (instr[6:5] == MV_A2S || instr[6:5] == MV_S2A))
					begin
						n.op = (instr[6:5] == MV_A2S) ? OP_MVA2S : OP_MVS2A;
						// first source read now, second in the next state
						n.raddr = (instr[6:5] == MV_A2S) ? REG_A0 : sreg_x({1'b0, instr[9:7]});
						n.st = S_MV;
					end
					else if (instr[12:10] == SEL_JT && !debug_mode)
					begin
						n.op = OP_JT;
						if (r.jvt_cause != CAUSE_NONE || {1'b0, instr[9:2]} >= r.jvt_cnt)
						begin
							n.fault.valid = 1'b1;
							n.fault.ftype = FT_IFETCH;
							n.fault.cause = (r.jvt_cause != CAUSE_NONE) ? r.jvt_cause : CAUSE_LEN;
						end
						else
						begin
							n.mem.valid = 1'b1;
							n.mem.we = 1'b0;
							n.mem.cap = 1'b0;
							n.mem.addr = jvt_cap.addr + XLEN'(instr[9:2]) * XLEN'(SLOT_INT);
							n.st = S_JT;
						end
					end
					else
						n.illegal = 1'b1;
					n.busy = (n.st != S_IDLE);
				end
			end
			S_PRD:
			begin
				cause = chk(auth, auth.perm_w, acc_addr, {1'b0, slot});
				if (cause != CAUSE_NONE)
				begin
					n.fault = '{valid: 1'b1, ftype: FT_DATA, cause: cause};
					n.st = S_IDLE;
					n.busy = 1'b0;
				end
				else
				begin
					n.mem.valid = 1'b1;
					n.mem.we = 1'b1;
					n.mem.cap = r.cm;
					n.mem.addr = acc_addr;
					n.mem.wdata = r.cm ? reg_rdata : {{XLEN{1'b0}}, reg_rdata[XLEN-1:0]};
					n.st = S_WAIT;
				end
			end
			S_LD:
			begin
				cause = chk(auth, auth.perm_r, acc_addr, {1'b0, slot});
				if (cause != CAUSE_NONE)
				begin
					n.fault = '{valid: 1'b1, ftype: FT_DATA, cause: cause};
					n.st = S_IDLE;
					n.busy = 1'b0;
				end
				else
				begin
					n.mem.valid = 1'b1;
					n.mem.we = 1'b0;
					n.mem.cap = r.cm;
					n.mem.addr = acc_addr;
					n.st = S_WAIT;
				end
			end
			S_WAIT:
			begin
				if (mem_ack)
				begin
					n.mem.valid = 1'b0;
					if (r.op != OP_PUSH)
					begin
						n.wr.valid = 1'b1;
						n.wr.addr = frame_x(r.k);
						n.wr.data = r.cm ? mem_rdata : {{XLEN{1'b0}}, mem_rdata[XLEN-1:0]};
					end
					n.k = r.k + 4'h1;
					n.raddr = frame_x(r.k + 4'h1);
					if (r.k + 4'h1 == r.nregs)
						n.st = S_SP;
					else
						n.st = (r.op == OP_PUSH) ? S_PRD : S_LD;
				end
			end
			S_SP:
			begin
				n.sp_we = 1'b1;
				n.sp_wdata = (r.op == OP_PUSH) ? r.sp - r.adj : r.sp + r.adj;
				if (r.op == OP_POPRETZ)
				begin
					n.wr.valid = 1'b1;
					n.wr.addr = REG_A0;
					n.wr.data = '0;
				end
				if (r.op == OP_POPRET || r.op == OP_POPRETZ)
					n.st = S_RET;
				else
				begin
					n.st = S_IDLE;
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
			S_RET:
			begin
				// ret_cap reflects the return register reloaded by this pop
				if (r.cm)
					cause = chk(ret_cap, ret_cap.perm_x, ret_cap.addr, {{XLEN{1'b0}}, 1'b1} + 1'b1);
				else
					cause = chk(pcc_cap, pcc_cap.perm_x, ret_cap.addr, {{XLEN{1'b0}}, 1'b1} + 1'b1);
				if (cause != CAUSE_NONE)
					n.fault = '{valid: 1'b1, ftype: FT_IFETCH, cause: cause};
				else
				begin
					n.jump = '{valid: 1'b1, link: 1'b0, target: ret_cap.addr};
					n.done = 1'b1;
				end
				n.st = S_IDLE;
				n.busy = 1'b0;
			end
			S_MV:
			begin
				if (r.k == 4'h0)
				begin
					n.wr.data = reg_rdata;
					n.raddr = (r.op == OP_MVA2S) ? REG_A1 : sreg_x({1'b0, r.s2});
					n.k = 4'h1;
				end
				else
				begin
					// both destinations written in the same cycle
					n.wr.valid = 1'b1;
					n.wr.valid2 = 1'b1;
					n.wr.addr = (r.op == OP_MVA2S) ? sreg_x({1'b0, r.index[7:5]}) : REG_A0;
					n.wr.addr2 = (r.op == OP_MVA2S) ? sreg_x({1'b0, r.s2}) : REG_A1;
					n.wr.data = r.cm ? r.wr.data : {{XLEN{1'b0}}, r.wr.data[XLEN-1:0]};
					n.wr.data2 = r.cm ? reg_rdata : {{XLEN{1'b0}}, reg_rdata[XLEN-1:0]};
					n.st = S_IDLE;
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
			S_JT:
			begin
				if (mem_ack)
				begin
					n.mem.valid = 1'b0;
					n.jump = '{valid: 1'b1, link: r.index >= JALT_MIN, target: mem_rdata[XLEN-1:0]};
					n.st = S_IDLE;
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
		endcase
	end

	// single state register; table range starts out invalid
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			r <= '0;
			r.st <= S_IDLE;
			r.jvt_cause <= CAUSE_TAG;
		end
		else
			r <= n;
	end

	assign busy = r.busy;
	assign reg_raddr = r.raddr;
	assign reg_wr = r.wr;
	assign mem = r.mem;
	assign sp_we = r.sp_we;
	assign sp_wdata = r.sp_wdata;
	assign jump = r.jump;
	assign fault = r.fault;
	assign illegal = r.illegal;
	assign done = r.done;

	logic [XLEN-1:0] sp_diff;
	assign sp_diff = sp_wdata - r.sp;

	sequence frame_gone_s;
		sp_we && (r.op == OP_POPRET || r.op == OP_POPRETZ);
	endsequence
	sequence ret_out_s;
		jump.valid || (fault.valid && fault.ftype == FT_IFETCH);
	endsequence

	reserved_rlist_a: assert property (@(posedge clk) disable iff (!nrst)
		r.st == S_IDLE && instr_valid && instr[1:0] == OPC_C2 && instr[15:13] == F3_ZCM
		&& instr[12:8] == SEL_PUSH && instr[7:4] < RLIST_MIN |=> illegal && !busy)
		else $error("reserved register list not rejected");
	adj_align_a: assert property (@(posedge clk) disable iff (!nrst)
		sp_we |-> sp_diff[3:0] == 4'h0)
		else $error("stack adjust not a multiple of 16");
	legacy_slot_a: assert property (@(posedge clk) disable iff (!nrst)
		mem.valid && r.op != OP_JT |-> mem.cap == r.cm)
		else $error("slot width does not match mode");
	push_fault_a: assert property (@(posedge clk) disable iff (!nrst)
		fault.valid && (r.op == OP_PUSH || r.op == OP_POP) |-> fault.ftype == FT_DATA)
		else $error("push or pop fault not a data fault");
	store_only_push_a: assert property (@(posedge clk) disable iff (!nrst)
		mem.valid && mem.we |-> r.op == OP_PUSH && $past(r.st) != S_IDLE)
		else $error("store outside push");
	return_after_a: assert property (@(posedge clk) disable iff (!nrst)
		frame_gone_s |=> ret_out_s)
		else $error("return missing after frame release");
	retz_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		sp_we && r.op == OP_POPRETZ |-> reg_wr.valid && reg_wr.addr == REG_A0 && reg_wr.data == '0)
		else $error("argument zero not cleared");
	pair_atomic_a: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr.valid2 |-> reg_wr.valid && done && $past(r.st) == S_MV && $past(r.st, 2) == S_MV)
		else $error("paired move writes split");
	debug_ret_a: assert property (@(posedge clk) disable iff (!nrst)
		r.st == S_IDLE && instr_valid && debug_mode && instr[1:0] == OPC_C2 && instr[15:13] == F3_ZCM
		&& (instr[12:8] == SEL_POPRET || instr[12:8] == SEL_POPRETZ) |=> illegal)
		else $error("return variant accepted in debug mode");
endmodule : cspe_exec

// ===== verification/cspe_mem_model.sv
`timescale 1ns/1ps
module cspe_mem_model (
	input  wire logic                      clk,
	input  wire cspe_pkg::cspe_mem_t       mem,
	input  wire logic                      slow,
	output logic                           mem_ack,
	output logic [cspe_pkg::CAPW-1:0]      mem_rdata
);
	import cspe_pkg::*;
	logic [CAPW-1:0] store [logic [XLEN-1:0]];
	// one request at a time; slow mode stretches every answer by three cycles
	initial
	begin
		mem_ack = 1'b0;
		mem_rdata = '0;
		forever
		begin
			@(posedge clk);
			if (mem.valid === 1'b1)
			begin
				repeat (slow ? 3 : 0) @(posedge clk);
				#1;
				if (mem.we)
					store[mem.addr] = mem.wdata;
				// unwritten words read back as their own address in the low half
				mem_rdata = store.exists(mem.addr) ? store[mem.addr] : {~mem.addr, mem.addr};
				mem_ack = 1'b1;
				@(posedge clk);
				#1;
				mem_ack = 1'b0;
				mem_rdata = ~mem_rdata; // released bus must not look valid
			end
		end
	end
endmodule : cspe_mem_model

// ===== verification/cap_stack_push_pop_exec_bench.sv
`timescale 1ns/1ps
module cap_stack_push_pop_exec_bench;
	import cspe_pkg::*;
	typedef struct packed {logic [4:0] a; logic [CAPW-1:0] d;} cspe_wr_t;
	localparam logic [XLEN-1:0] S = 32'h0000_1000;
	localparam logic [XLEN-1:0] R = 32'h0000_0200;
	localparam logic [XLEN-1:0] J = 32'h0000_3000;
	localparam cspe_cap_t GOOD = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 32'h0000_0000, 33'h1_0000_0000, R};
	logic            clk, nrst, instr_valid, cap_mode, debug_mode, jvt_write, mem_ack, slow;
	logic [15:0]     instr;
	logic [XLEN-1:0] sp_addr, sp_wdata, sp_seen;
	cspe_cap_t       sp_cap, ddc_cap, pcc_cap, ret_cap, jvt_cap;
	logic [CAPW-1:0] reg_rdata, mem_rdata;
	logic            busy, sp_we, illegal, done, ill, fin;
	logic [4:0]      reg_raddr;
	cspe_regwr_t     reg_wr;
	cspe_mem_t       mem;
	cspe_jump_t      jump, jv;
	cspe_fault_t     fault, fv;
	cspe_wr_t        rq[$];
	cspe_mem_t       mq[$];
	int              pairs, bz, n_errors, checked;
	function automatic logic [CAPW-1:0] rv(input logic [4:0] a);
		return {27'h500_0000, a, 27'h0, a};
	endfunction : rv
	function automatic logic [CAPW-1:0] ex(input logic cm, input logic [4:0] a);
		return cm ? rv(a) : {59'h0, a}; // legacy values arrive zero-extended
	endfunction : ex
	function automatic logic [4:0] smap(input int s);
		return (s < 2) ? REG_S0 + 5'(s) : REG_S2_OFS + 5'(s);
	endfunction : smap
	function automatic logic [4:0] sreg(input int k);
		return (k == 0) ? REG_RA : smap(k - 1);
	endfunction : sreg
	function automatic logic [15:0] stk(input logic [4:0] sel, input logic [3:0] rl, input logic [1:0] spi);
		return {F3_ZCM, sel, rl, spi, OPC_C2};
	endfunction : stk
	function automatic cspe_cap_t spoil(input int c, input int p);
		cspe_cap_t g;
		g = GOOD;
		if (c == 0) g.tag = 1'b0;
		if (c == 1) g.sealed = 1'b1;
		if (c == 2 && p == 0) g.perm_w = 1'b0;
		if (c == 2 && p == 1) g.perm_r = 1'b0;
		if (c == 2 && p == 2) g.perm_x = 1'b0;
		if (c == 3) g.base = S;
		return g;
	endfunction : spoil
	cspe_exec u_cspe_exec (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr), .cap_mode(cap_mode),
		.debug_mode(debug_mode), .sp_addr(sp_addr), .sp_cap(sp_cap), .ddc_cap(ddc_cap), .pcc_cap(pcc_cap),
		.ret_cap(ret_cap), .jvt_cap(jvt_cap), .jvt_write(jvt_write), .reg_rdata(reg_rdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .busy(busy), .reg_raddr(reg_raddr), .reg_wr(reg_wr), .mem(mem), .sp_we(sp_we),
		.sp_wdata(sp_wdata), .jump(jump), .fault(fault), .illegal(illegal), .done(done));
	cspe_mem_model u_cspe_mem_model (.clk(clk), .mem(mem), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// combinational register file: every register holds a value built from its number
	assign reg_rdata = rv(reg_raddr);
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// record results at the falling edge, clear of the rising-edge updates
	always @(negedge clk)
	begin
		if (mem.valid && mem_ack) mq.push_back(mem);
		if (reg_wr.valid) rq.push_back({reg_wr.addr, reg_wr.data});
		if (reg_wr.valid2) rq.push_back({reg_wr.addr2, reg_wr.data2});
		if (reg_wr.valid && reg_wr.valid2) pairs++;
		if (busy) bz++;
		if (sp_we) sp_seen = sp_wdata;
		if (jump.valid) jv = jump;
		if (fault.valid) fv = fault;
		if (illegal) ill = 1'b1;
		fin = fin | done | fault.valid | illegal;
	end
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [CAPW-1:0] seen, input logic [CAPW-1:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : chk
	task automatic setup(input logic cm, input logic [XLEN-1:0] sp, input int w, input int c, input int p);
		@(negedge clk);
		cap_mode = cm;
		sp_addr = sp;
		sp_cap = (w == 1) ? spoil(c, p) : GOOD;
		ddc_cap = (w == 2) ? spoil(c, p) : GOOD;
		pcc_cap = (w == 3) ? spoil(c, p) : GOOD;
		ret_cap = (w == 4) ? spoil(c, p) : GOOD;
	endtask : setup
	// one instruction, then wait for its closing pulse under a bound
	task automatic op(input logic [15:0] i);
		@(posedge clk);
		mq.delete();
		rq.delete();
		{ill, fin, pairs, bz, jv, fv} = '0;
		sp_seen = 'x;
		@(negedge clk);
		instr = i;
		instr_valid = 1'b1;
		@(negedge clk);
		instr_valid = 1'b0;
		for (int c = 0; c < 400 && !fin; c++) @(posedge clk);
		if (!fin)
		begin
			n_errors++;
			$display("wrong value at %0t: operation hung", $time);
			test_done;
		end
	endtask : op
	task automatic t_frame(input logic cm, input logic [3:0] rl, input logic [1:0] spi);
		int n, sl, adj;
		n = (rl == RLIST_ALL) ? int'(ALL_REGS) : int'(rl) - 3;
		sl = cm ? SLOT_CAP : SLOT_INT;
		adj = (n * sl + 15) / 16 * 16 + int'(spi) * ADJ_UNIT;
		setup(cm, S, 0, 0, 0);
		op(stk(SEL_PUSH, rl, spi));
		chk(mq.size(), n, "push slot count");
		for (int k = 0; k < n; k++)
		begin
			chk(mq[k].addr, S - (k + 1) * sl, "push address");
			chk({mq[k].we, mq[k].cap}, {1'b1, cm}, "push kind");
			chk(cm ? mq[k].wdata : CAPW'(mq[k].wdata[XLEN-1:0]), ex(cm, sreg(k)), "push data");
		end
		chk(sp_seen, S - adj, "push stack pointer");
		setup(cm, S - adj, 0, 0, 0);
		op(stk(SEL_POP, rl, spi));
		chk(rq.size(), n, "pop register count");
		for (int k = 0; k < n; k++)
		begin
			chk({mq[k].we, mq[k].addr}, {1'b0, S - (k + 1) * sl}, "pop address");
			chk(rq[k].a, sreg(k), "pop register");
			chk(rq[k].d, ex(cm, sreg(k)), "pop data");
		end
		chk(sp_seen, S, "pop stack pointer");
		$display("frame test done");
	endtask : t_frame
	task automatic t_ret(input logic cm, input logic z);
		setup(cm, S, cm ? 3 : 4, 0, 0);
		op(stk(z ? SEL_POPRETZ : SEL_POPRET, 4'h4, 2'h0));
		chk({jv.valid, jv.link, jv.target}, {2'b10, R}, "return jump");
		chk(sp_seen, S + 16, "return stack pointer");
		chk({fv.valid, mq[0].cap}, {1'b0, cm}, "return loads");
		chk(rq.size(), 1 + z, "return writes");
		if (z) chk({rq[1].a, rq[1].d}, {REG_A0, 64'h0}, "zero argument");
		$display("return test done");
	endtask : t_ret
	task automatic t_faults;
		for (int m = 0; m < 2; m++)
			for (int c = 0; c < 4; c++)
			begin
				setup(m[0], S, m ? 1 : 2, c, 0);
				op(stk(SEL_PUSH, 4'h5, 2'h0));
				chk(fv, {1'b1, FT_DATA, 4'(c + 1)}, "push fault");
				setup(m[0], S - 64, m ? 1 : 2, c, 1);
				op(stk(SEL_POPRET, 4'h5, 2'h0));
				chk(fv, {1'b1, FT_DATA, 4'(c + 1)}, "load fault");
				setup(m[0], S - 64, m ? 4 : 3, c, 2);
				op(stk(SEL_POPRET, 4'h5, 2'h0));
				chk(fv, {1'b1, FT_IFETCH, 4'(c + 1)}, "return fault");
			end
		$display("fault test done");
	endtask : t_faults
	task automatic t_moves;
		logic cm;
		for (int i = 0; i < 8; i++)
		begin
			cm = i[0];
			setup(cm, S, 0, 0, 0);
			op({F3_ZCM, SEL_MV, 3'(i), MV_A2S, 3'(7 - i), OPC_C2});
			chk(pairs, 1, "move pair");
			chk({rq[0].a, rq[1].a}, {smap(i), smap(7 - i)}, "move targets");
			chk(rq[0].d, ex(cm, REG_A0), "move first");
			chk(rq[1].d, ex(cm, REG_A1), "move second");
			chk(bz, 2, "move busy cycles");
			op({F3_ZCM, SEL_MV, 3'(i), MV_S2A, 3'(7 - i), OPC_C2});
			chk(pairs, 1, "move pair");
			chk({rq[0].a, rq[1].a}, {REG_A0, REG_A1}, "move targets");
			chk(rq[0].d, ex(cm, smap(i)), "move first");
			chk(rq[1].d, ex(cm, smap(7 - i)), "move second");
		end
		$display("move test done");
	endtask : t_moves
	task automatic t_table;
		int ix[3] = '{3, 39, 40};
		setup(1'b1, S, 3, 0, 0);
		op({F3_ZCM, SEL_JT, 8'h03, OPC_C2});
		chk(fv, {1'b1, FT_IFETCH, CAUSE_TAG}, "table before write");
		@(negedge clk);
		jvt_cap = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, J, {1'b0, J + 160}, J};
		jvt_write = 1'b1;
		@(negedge clk);
		jvt_write = 1'b0;
		foreach (ix[t])
		begin
			op({F3_ZCM, SEL_JT, 8'(ix[t]), OPC_C2});
			if (ix[t] < 40)
			begin
				chk({mq[0].cap, mq[0].addr}, {1'b0, J + 4 * ix[t]}, "table read");
				chk({jv.valid, jv.link, jv.target}, {1'b1, ix[t] >= 32, J + 4 * ix[t]}, "table jump");
			end
			else
				chk(fv, {1'b1, FT_IFETCH, CAUSE_LEN}, "table range");
		end
		$display("table test done");
	endtask : t_table
	task automatic t_illegal;
		for (int rl = 0; rl < 4; rl++)
		begin
			setup(1'b0, S, 0, 0, 0);
			op(stk(rl[0] ? SEL_POP : SEL_PUSH, 4'(rl), 2'h0));
			chk({ill, 1'(mq.size())}, 2'b10, "reserved list");
		end
		setup(1'b1, S, 0, 0, 0);
		debug_mode = 1'b1;
		op(stk(SEL_POPRET, 4'h4, 2'h0));
		chk(ill, 1'b1, "debug return");
		op(stk(SEL_POPRETZ, 4'h4, 2'h0));
		chk(ill, 1'b1, "debug return");
		@(negedge clk);
		debug_mode = 1'b0;
		$display("illegal test done");
	endtask : t_illegal
	// reset, then every scenario in turn
	initial
	begin
		{instr_valid, cap_mode, debug_mode, jvt_write, slow, nrst} = '0;
		{instr, n_errors, checked} = '0;
		sp_addr = S;
		{sp_cap, ddc_cap, pcc_cap, ret_cap, jvt_cap} = {5{GOOD}};
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		t_table;
		t_frame(1'b0, 4'h5, 2'h1);
		t_frame(1'b1, 4'h6, 2'h0);
		slow = 1'b1;
		t_frame(1'b1, 4'hf, 2'h3);
		slow = 1'b0;
		t_ret(1'b0, 1'b0);
		t_ret(1'b1, 1'b1);
		t_ret(1'b1, 1'b0);
		t_ret(1'b0, 1'b1);
		t_faults;
		t_moves;
		t_illegal;
		test_done;
	end
endmodule : cap_stack_push_pop_exec_bench
